// ==== dv/pmu_seq_props.sv ====
/*
 Port checker for pmu_sequencer, bound to every instance.
 Assumes the one clock clk and the asynchronous reset rst.
*/
module pmu_seq_props #(
   parameter int RESET_HOLD = 50,
   parameter int WAKE_PULSE = 20
) (
   input wire clk,
   input wire rst,
   input wire reset_in_n,
   input wire vin_present,
   input wire system_supply_enable,
   input wire low_voltage_supply_enable,
   input wire [5:0] temp_cmp,
   input wire scl,
   input wire sda_oe,
   input wire reset_out_n,
   input wire main_battery_fault_n,
   input wire core_logic_regulator,
   input wire hv_others_en,
   input wire lv_en,
   input wire [5:0] cmp_en,
   input wire wakeup
);
   timeunit 1ns;
   timeprecision 1ns;
   int low_cnt;
   int wake_cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ------------
   // Pulse lengths
   // ------------
   // Cycles spent in reset and in wake-up
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         low_cnt <= 0;
         wake_cnt <= 0;
      end else begin
         low_cnt <= reset_out_n ? 0 : low_cnt + 1;
         wake_cnt <= wakeup ? wake_cnt + 1 : 0;
      end
   end
   // ------------
   // Properties
   // ------------
   sequence s_warn_rise; !temp_cmp[5] ##1 temp_cmp[5]; endsequence
   sequence s_vin_off; !vin_present [*5]; endsequence
   sequence s_sys_on; system_supply_enable [*5]; endsequence
   property p_cmp; cmp_en == 6'h30 || cmp_en == 6'h3F; endproperty
   a_cmp: assert property (p_cmp) else $error("bad enables");
   property p_wake_rise; s_warn_rise |-> ##[1:5] wakeup; endproperty
   a_wake_rise: assert property (p_wake_rise) else $error("no wake");
   property p_wake_len; $fell(wakeup) |-> wake_cnt >= WAKE_PULSE; endproperty
   a_wake_len: assert property (p_wake_len) else $error("wake short");
   property p_hold; $rose(reset_out_n) |-> low_cnt >= RESET_HOLD; endproperty
   a_hold: assert property (p_hold) else $error("reset short");
   property p_ext; $fell(reset_in_n) |-> ##[1:5] !reset_out_n; endproperty
   a_ext: assert property (p_ext) else $error("no reset");
   property p_fault; s_vin_off |-> !main_battery_fault_n; endproperty
   a_fault: assert property (p_fault) else $error("fault off");
   property p_core; s_sys_on |-> core_logic_regulator; endproperty
   a_core: assert property (p_core) else $error("core off");
   property p_order; hv_others_en |-> core_logic_regulator; endproperty
   a_order: assert property (p_order) else $error("core late");
   property p_lv; low_voltage_supply_enable [*5] |-> lv_en; endproperty
   a_lv: assert property (p_lv) else $error("lv off");
   property p_sda; $changed(sda_oe) |-> !scl; endproperty
   a_sda: assert property (p_sda) else $error("sda moved");
endmodule // pmu_seq_props

bind pmu_sequencer pmu_seq_props #(.RESET_HOLD(RESET_HOLD),
   .WAKE_PULSE(WAKE_PULSE)) u_props (.clk, .rst, .reset_in_n,
   .vin_present, .system_supply_enable, .low_voltage_supply_enable,
   .temp_cmp, .scl, .sda_oe, .reset_out_n, .main_battery_fault_n,
   .core_logic_regulator, .hv_others_en, .lv_en, .cmp_en, .wakeup);

// ==== dv/pmu_sequencer_thermal_i2c_tb.sv ====
/*
 Self-checking bench for pmu_sequencer with short time constants.
 Assumes twi_master and the bound checker are compiled first.
*/
`include "pmu_seq_defines.vh"
module pmu_sequencer_thermal_i2c_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HOLD = 50;
   localparam int WAKE = 20;
   localparam int STEP = 5;
   typedef struct {logic [7:0] idx, d, m, e; logic [5:0] c;} row_t;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic rtc_ok = 1'h1;
   logic rin_n = 1'h1;
   logic vin = 1'h0;
   logic sys = 1'h0;
   logic pwr = 1'h0;
   logic [5:0] temp = 6'h07;
   logic [5:0] ok = 6'h2A;
   logic [7:0] q;
   logic nak;
   row_t r;
   int err_count = 0;
   int total_checks = 0;
   int n;
   wire scl, sda, sda_oe, rst_o_n, flt_n, core, others, lv, wake;
   wire [5:0] cmp_en;
   wire [3:0] obs = {wake, others, core, rst_o_n};
   row_t rows [6] = '{
      '{{4'h0, `REG_DELAY}, 8'h30, 8'h30, 8'h30, 6'h30},
      '{{4'h0, `REG_STATUS}, 8'hFF, 8'h3F, 8'h2A, 6'h30},
      '{{4'h0, `REG_CTRL}, 8'h01, 8'h07, 8'h01, 6'h3F},
      '{{4'h0, `REG_TEMP}, 8'h00, 8'h07, 8'h03, 6'h3F},
      '{{4'h0, `REG_CTRL}, 8'h00, 8'h07, 8'h00, 6'h30},
      '{{4'h0, `REG_TEMP}, 8'hFF, 8'h07, 8'h00, 6'h30}};
   pmu_sequencer #(.RESET_HOLD(HOLD), .WAKE_PULSE(WAKE),
      .DELAY_STEP(STEP)) dut (.clk(clk), .rst(rst),
      .rtc_regulator_ok(rtc_ok), .reset_in_n(rin_n), .vin_present(vin),
      .system_supply_enable(sys), .low_voltage_supply_enable(pwr),
      .temp_cmp(temp), .reg_ok(ok), .scl(scl), .sda_in(sda), .sda_out(),
      .sda_oe(sda_oe), .reset_out_n(rst_o_n), .main_battery_fault_n(flt_n),
      .core_logic_regulator(core), .hv_others_en(others), .lv_en(lv),
      .cmp_en(cmp_en), .wakeup(wake));
   twi_master m (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   // ------------
   // Helpers
   // ------------
   always #20 clk = ~clk;
   task chk(input logic [31:0] got, exp, input string s);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t %s", $time, s);
      end
   endtask
   // Edges until an output reaches a level
   task wait_for(input int b, input logic lvl, output int c);
      c = 0;
      while (obs[b] !== lvl && c < 400) begin
         @(posedge clk);
         c++;
      end
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Cuts a hung run short
   initial begin
      repeat (30000) @(posedge clk);
      err_count++;
      complete_run;
   end
   // ------------
   // Tests
   // ------------
   initial begin
      repeat (6) @(posedge clk);
      chk({rst_o_n, flt_n, core, others, lv, wake, cmp_en}, 12'h030, "rst");
      rst <= 1'h0;
      wait_for(0, 1'h1, n);
      chk(n >= HOLD && n < 400, 1, "cold hold");
      chk(flt_n, 0, "fault early");
      vin <= 1'h1;
      repeat (5) @(posedge clk);
      chk(flt_n, 1, "fault stuck");
      m.rd({4'h0, `REG_DELAY}, q);
      chk(q & 8'h30, 8'h20, "delay reset");
      foreach (rows[i]) begin
         r = rows[i];
         m.wr(r.idx, r.d, nak);
         m.rd(r.idx, q);
         chk({nak, q & r.m, cmp_en}, {1'h0, r.e, r.c}, "row");
      end
      $display("test done: power-on and registers");
      for (int s = 0; s < 2; s++) begin
         sys <= 1'h0;
         m.wr({4'h0, `REG_DELAY}, 8'(s << 4), nak);
         sys <= 1'h1;
         wait_for(1, 1'h1, n);
         wait_for(2, 1'h1, n);
         chk(n >= s * STEP && n <= s * STEP + 2, 1, "others");
      end
      repeat (20) @(posedge clk);
      pwr <= 1'h1;
      repeat (5) @(posedge clk);
      chk(lv, 1, "pin enable");
      pwr <= 1'h0;
      repeat (5) @(posedge clk);
      chk(lv, 0, "pin disable");
      m.rd({4'h0, `REG_STATUS}, q);
      chk(q & 8'h3F, 8'h2A, "ok status");
      m.wr({4'h0, `REG_CTRL}, 8'h02, nak);
      chk(lv, 1, "register enable");
      $display("test done: supplies");
      m.start;
      m.xfer({7'h35, 1'h0}, 1'h1, q, nak);
      chk(nak, 1, "foreign ack");
      m.xfer(8'h00, 1'h1, q, nak);
      m.xfer(8'h01, 1'h1, q, nak);
      m.stop;
      m.rd({4'h0, `REG_CTRL}, q);
      chk({q & 8'h07, cmp_en}, {8'h02, 6'h30}, "foreign write");
      $display("test done: foreign address");
      rin_n <= 1'h0;
      repeat (2) @(posedge clk);
      rin_n <= 1'h1;
      repeat (5) @(posedge clk);
      chk(rst_o_n, 0, "no reset");
      wait_for(0, 1'h1, n);
      chk(n >= HOLD - 4 && n < 400, 1, "reset hold");
      temp <= 6'h27;
      wait_for(3, 1'h1, n);
      chk(n < 8, 1, "no wakeup");
      wait_for(3, 1'h0, n);
      chk(n >= WAKE && n <= WAKE + 1, 1, "wake length");
      $display("test done: reset and wake-up");
      complete_run;
   end
endmodule // pmu_sequencer_thermal_i2c_tb

// ==== dv/twi_master.sv ====
/*
 Two-wire bus master standing in for the processor.
 Assumes the bench clock clk; one bus bit lasts ten clk cycles.
*/
`include "pmu_seq_defines.vh"
module twi_master (
   input wire clk,
   input wire sda_oe,
   output logic scl,
   output wire sda
);
   timeunit 1ns;
   timeprecision 1ns;
   logic m_low;
   // ------------
   // Bus cycles
   // ------------
   // Open drain with pull-up
   assign sda = !(m_low || sda_oe);
   initial begin
      scl = 1'h1;
      m_low = 1'h0;
   end
   task hp;
      repeat (4) @(posedge clk);
   endtask
   // Start, also repeated start
   task start;
      @(posedge clk) m_low <= 1'h0;
      hp;
      scl <= 1'h1;
      hp;
      m_low <= 1'h1;
      hp;
      scl <= 1'h0;
   endtask
   task stop;
      @(posedge clk) m_low <= 1'h1;
      hp;
      scl <= 1'h1;
      hp;
      m_low <= 1'h0;
      hp;
   endtask
   // Data moves while clock low
   task bit_x(input logic b, output logic r);
      @(posedge clk) m_low <= !b;
      repeat (5) @(posedge clk);
      scl <= 1'h1;
      hp;
      r = sda;
      scl <= 1'h0;
   endtask
   // Eight bits MSB first, then acknowledge
   task xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
      output logic a);
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      bit_x(ai, a);
   endtask
   task wr(input logic [7:0] idx, d, output logic nak);
      logic [7:0] q;
      logic a0, a1, a2;
      start;
      xfer({`SLAVE_ADDR, 1'h0}, 1'h1, q, a0);
      xfer(idx, 1'h1, q, a1);
      xfer(d, 1'h1, q, a2);
      stop;
      nak = a0 | a1 | a2;
   endtask
   // Index write, then repeated start to read
   task rd(input logic [7:0] idx, output logic [7:0] q);
      logic a;
      start;
      xfer({`SLAVE_ADDR, 1'h0}, 1'h1, q, a);
      xfer(idx, 1'h1, q, a);
      start;
      xfer({`SLAVE_ADDR, 1'h1}, 1'h1, q, a);
      xfer(8'hFF, 1'h1, q, a);
      stop;
   endtask
endmodule // twi_master

// ==== rtl/pmu_seq_defines.vh ====
/*
 Constants for the power sequencer and its two-wire slave port.
 Assumes a 25 MHz system clock; times are derived from it by integer math.
*/
`ifndef PMU_SEQ_DEFINES_VH
`define PMU_SEQ_DEFINES_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_HZ 25000000
`define RESET_HOLD_MS 50
`define RESET_HOLD_CYC ((`CLK_HZ / 1000) * `RESET_HOLD_MS)
`define WAKE_PULSE_MS 10
`define WAKE_PULSE_CYC ((`CLK_HZ / 1000) * `WAKE_PULSE_MS)
`define DELAY_STEP_US 500
`define DELAY_STEP_CYC ((`CLK_HZ / 1000000) * `DELAY_STEP_US)

// ----------------------------------------------------------------------
// Two-wire slave
// ----------------------------------------------------------------------
`define SLAVE_ADDR 7'h34
`define NUM_REGS 16

// ----------------------------------------------------------------------
// Register indices and fields
// ----------------------------------------------------------------------
`define REG_CTRL 4'h0
`define REG_DELAY 4'h1
`define REG_STATUS 4'h2
`define REG_TEMP 4'h3
`define CTRL_ALLFLAGS 0
`define CTRL_LV_EN 1
`define CTRL_HV_EN 2
`define DELAY_LSB 4
`define DELAY_MSB 5
`define DELAY_RESET 8'h20
`define TEMP_LSB 0
`define TEMP_MSB 2

`endif

// ==== rtl/pmu_sequencer.v ====
/*
 Power-up/reset sequencer, thermal flags, wake-up and register port.
 Assumes pin inputs are asynchronous; the two-wire clock is a plain input.
*/
`include "pmu_seq_defines.vh"

module pmu_sequencer #(
   parameter RESET_HOLD = `RESET_HOLD_CYC,
   parameter WAKE_PULSE = `WAKE_PULSE_CYC,
   parameter DELAY_STEP = `DELAY_STEP_CYC
) (
   input wire clk,
   input wire rst,
   input wire rtc_regulator_ok,
   input wire reset_in_n,
   input wire vin_present,
   input wire system_supply_enable,
   input wire low_voltage_supply_enable,
   input wire [5:0] temp_cmp,
   input wire [5:0] reg_ok,
   input wire scl,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe,
   output reg reset_out_n,
   output reg main_battery_fault_n,
   output reg core_logic_regulator,
   output reg hv_others_en,
   output reg lv_en,
   output reg [5:0] cmp_en,
   output reg wakeup
);
   localparam R_IDLE = 2'd0;
   localparam R_HOLD = 2'd1;
   localparam R_DONE = 2'd2;

   // ------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------
   localparam NSYNC = 19;
   // Idle levels: reset request, clock and data rest high
   localparam [NSYNC-1:0] SYNC_IDLE = 19'h20003;
   wire [NSYNC-1:0] raw = {rtc_regulator_ok, reset_in_n, vin_present,
      system_supply_enable, low_voltage_supply_enable, temp_cmp, reg_ok,
      scl, sda_in};
   reg [NSYNC-1:0] sync1;
   reg [NSYNC-1:0] sync2;
   genvar g;
   generate
      for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
         // Two-stage synchroniser per pin
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               sync1[g] <= SYNC_IDLE[g];
               sync2[g] <= SYNC_IDLE[g];
            end else begin
               sync1[g] <= raw[g];
               sync2[g] <= sync1[g];
            end
         end
      end
   endgenerate
   wire s_rtc_ok = sync2[18];
   wire s_rst_in_n = sync2[17];
   wire s_vin = sync2[16];
   wire s_system_supply_enable = sync2[15];
   wire s_low_voltage_supply_enable = sync2[14];
   wire [5:0] s_temp = sync2[13:8];
   wire [5:0] s_ok = sync2[7:2];
   wire s_scl = sync2[1];
   wire s_sda = sync2[0];

   // ------------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------------
   reg [7:0] regs [0:`NUM_REGS-1];
   wire [7:0] reg_idx;
   wire [7:0] wr_data;
   wire wr_stb;
   reg [2:0] temp_code;
   wire [3:0] idx = reg_idx[3:0];
   wire [7:0] rd_data = (idx == `REG_STATUS) ?
      {2'b00, s_ok} :
      (idx == `REG_TEMP) ? {5'b00000, temp_code} : regs[idx];
   assign sda_out = 1'b0;

   twi_slave u_twi (
      .clk(clk),
      .rst(rst),
      .scl(s_scl),
      .sda_in(s_sda),
      .sda_oe(sda_oe),
      .reg_idx(reg_idx),
      .wr_data(wr_data),
      .wr_stb(wr_stb),
      .rd_data(rd_data)
   );

   integer i;
   // Register writes from the slave port
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         for (i = 0; i < `NUM_REGS; i = i + 1)
            regs[i] <= 8'h00;
         regs[`REG_DELAY] <= `DELAY_RESET;
      end else if (wr_stb && reg_idx[7:4] == 4'h0) begin
         regs[idx] <= wr_data;
      end
   end
   wire allflags = regs[`REG_CTRL][`CTRL_ALLFLAGS];
   wire sw_lv_en = regs[`REG_CTRL][`CTRL_LV_EN];
   wire sw_hv_en = regs[`REG_CTRL][`CTRL_HV_EN];
   wire [1:0] delay_sel = regs[`REG_DELAY][`DELAY_MSB:`DELAY_LSB];

   // ------------------------------------------------------------------
   // Thermal flags and wake-up
   // ------------------------------------------------------------------
   reg warn_d;
   reg [19:0] wake_cnt;
   wire warn = s_temp[5];
   // Count of set flags, each widened to three bits
   wire [2:0] flag_sum = {2'b00, s_temp[0]} + {2'b00, s_temp[1]} +
      {2'b00, s_temp[2]} + {2'b00, s_temp[3]} + {2'b00, s_temp[4]} +
      {2'b00, s_temp[5]};
   // Comparator enables and coded temperature
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cmp_en <= 6'b110000;
         temp_code <= 3'b000;
         warn_d <= 1'b0;
         wake_cnt <= 20'h00000;
         wakeup <= 1'b0;
      end else begin
         cmp_en <= allflags ? 6'b111111 : 6'b110000;
         // Thermometer flags to binary count
         temp_code <= allflags ? flag_sum : 3'b000;
         warn_d <= warn;
         if (warn && !warn_d) begin
            wake_cnt <= WAKE_PULSE[19:0];
            wakeup <= 1'b1;
         end else if (wake_cnt > 20'h00001) begin
            wake_cnt <= wake_cnt - 20'h00001;
         end else begin
            wake_cnt <= 20'h00000;
            wakeup <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Reset output sequencing
   // ------------------------------------------------------------------
   reg [1:0] rstate;
   reg [20:0] hold_cnt;
   // Power-up and external reset hold
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rstate <= R_IDLE;
         hold_cnt <= 21'h000000;
         reset_out_n <= 1'b0;
      end else begin
         case (rstate)
            R_IDLE: begin
               reset_out_n <= 1'b0;
               if (s_rtc_ok) begin
                  rstate <= R_HOLD;
                  hold_cnt <= RESET_HOLD[20:0];
               end
            end
            R_HOLD: begin
               reset_out_n <= 1'b0;
               if (!s_rst_in_n)
                  hold_cnt <= RESET_HOLD[20:0];
               else if (hold_cnt > 21'h000001)
                  hold_cnt <= hold_cnt - 21'h000001;
               else
                  rstate <= R_DONE;
            end
            R_DONE: begin
               reset_out_n <= 1'b1;
               if (!s_rst_in_n) begin
                  rstate <= R_HOLD;
                  hold_cnt <= RESET_HOLD[20:0];
                  reset_out_n <= 1'b0;
               end
            end
            default: rstate <= R_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Supply enables
   // ------------------------------------------------------------------
   reg [15:0] seq_cnt;
   wire hv_req = s_system_supply_enable | sw_hv_en;
   wire [31:0] seq_prod = DELAY_STEP * delay_sel;
   wire [15:0] seq_target = seq_prod[15:0];
   // Battery fault, high and low voltage groups
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         main_battery_fault_n <= 1'b0;
         core_logic_regulator <= 1'b0;
         hv_others_en <= 1'b0;
         lv_en <= 1'b0;
         seq_cnt <= 16'h0000;
      end else begin
         main_battery_fault_n <= s_vin;
         lv_en <= s_low_voltage_supply_enable | sw_lv_en;
         if (!hv_req) begin
            core_logic_regulator <= 1'b0;
            hv_others_en <= 1'b0;
            seq_cnt <= 16'h0000;
         end else begin
            core_logic_regulator <= 1'b1;
            if (seq_cnt >= seq_target)
               hv_others_en <= 1'b1;
            else
               seq_cnt <= seq_cnt + 16'h0001;
         end
      end
   end
endmodule // pmu_sequencer

// ==== rtl/twi_slave.v ====
/*
 Two-wire slave at address SLAVE_ADDR: register index then data byte(s).
 Assumes scl/sda inputs are already synchronised to clk.
*/
`include "pmu_seq_defines.vh"

module twi_slave (
   input wire clk,
   input wire rst,
   input wire scl,
   input wire sda_in,
   output reg sda_oe,
   output reg [7:0] reg_idx,
   output reg [7:0] wr_data,
   output reg wr_stb,
   input wire [7:0] rd_data
);
   localparam S_IDLE = 3'd0;
   localparam S_ADDR = 3'd1;
   localparam S_INDEX = 3'd2;
   localparam S_WDATA = 3'd3;
   localparam S_RDATA = 3'd4;
   localparam S_IGNORE = 3'd5;

   reg scl_d;
   reg sda_d;
   reg [2:0] state;
   reg [3:0] bit_cnt;
   reg [7:0] shift;
   reg ack_phase;
   reg reading;
   wire scl_rise = scl & ~scl_d;
   wire scl_fall = ~scl & scl_d;
   wire start_det = scl & scl_d & sda_d & ~sda_in;
   wire stop_det = scl & scl_d & ~sda_d & sda_in;

   // ------------------------------------------------------------------
   // Bus state machine
   // ------------------------------------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         state <= S_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         ack_phase <= 1'b0;
         reading <= 1'b0;
         sda_oe <= 1'b0;
         reg_idx <= 8'h00;
         wr_data <= 8'h00;
         wr_stb <= 1'b0;
      end else begin
         scl_d <= scl;
         sda_d <= sda_in;
         wr_stb <= 1'b0;
         if (start_det) begin
            // Repeated start behaves as a first start
            state <= S_ADDR;
            bit_cnt <= 4'h0;
            ack_phase <= 1'b0;
            sda_oe <= 1'b0;
         end else if (stop_det) begin
            state <= S_IDLE;
            sda_oe <= 1'b0;
         end else if (state != S_IDLE && state != S_IGNORE) begin
            if (scl_rise && !ack_phase) begin
               // Read bytes shift out on falls only
               if (state != S_RDATA)
                  shift <= {shift[6:0], sda_in};
               bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_rise && ack_phase && reading) begin
               // Master nack ends the read
               if (sda_in)
                  state <= S_IGNORE;
            end
            if (scl_fall) begin
               if (!ack_phase && bit_cnt == 4'h8) begin
                  ack_phase <= 1'b1;
                  bit_cnt <= 4'h0;
                  case (state)
                     S_ADDR: begin
                        if (shift[7:1] == `SLAVE_ADDR) begin
                           sda_oe <= 1'b1;
                           reading <= shift[0];
                        end else begin
                           state <= S_IGNORE;
                        end
                     end
                     S_INDEX: begin
                        reg_idx <= shift;
                        sda_oe <= 1'b1;
                     end
                     S_WDATA: begin
                        wr_data <= shift;
                        wr_stb <= 1'b1;
                        sda_oe <= 1'b1;
                     end
                     S_RDATA: sda_oe <= 1'b0;
                     default: sda_oe <= 1'b0;
                  endcase
               end else if (!ack_phase && state == S_RDATA) begin
                  sda_oe <= ~shift[7];
                  shift <= {shift[6:0], 1'b1};
               end else if (ack_phase) begin
                  ack_phase <= 1'b0;
                  sda_oe <= 1'b0;
                  case (state)
                     S_ADDR: begin
                        if (reading) begin
                           state <= S_RDATA;
                           sda_oe <= ~rd_data[7];
                           shift <= {rd_data[6:0], 1'b1};
                           bit_cnt <= 4'h0;
                        end else begin
                           state <= S_INDEX;
                        end
                     end
                     S_INDEX: state <= S_WDATA;
                     S_WDATA: state <= S_WDATA;
                     S_RDATA: begin
                        sda_oe <= ~rd_data[7];
                        shift <= {rd_data[6:0], 1'b1};
                        bit_cnt <= 4'h0;
                     end
                     default: state <= S_IGNORE;
                  endcase
               end
            end
         end
      end
   end
endmodule // twi_slave
